// ===== verilog/spi_fifo_consts.svh
// Behaviour
// [RULE1] Master polls the device often for waiting transmit data, ideally first.
// [RULE2] Data read: after start and setup bits, shift out one byte, then result.
// [RULE3] Read result 0 means fresh byte, now removed; 1 means repeated old byte.
// [RULE4] On read result 1 the master drops the byte and reads again.
// [RULE5] Result bit holds only until the clock edge after the last data bit.
// [RULE6] Master keeps chip select high through a whole data read.
// [RULE7] A frame lasts 13 clocks; next starts on SDI and CS high at an edge.
// [RULE8] Data write: start, setup, eight data bits, then result on next edge.
// [RULE9] Write result 0 means byte stored; 1 means receive buffer full, dropped.
// [RULE10] Master samples the result bit at the end of every write.
// [RULE11] After a rejected write the master resends the same byte.
// [RULE12] Status read: shift out the status byte, then a result of zero.
// [RULE13] Status bits: 0 rx full, 1 tx empty, 4 and 5 the enables.
// [RULE14] Status is current only in its frame; data results still checked.
// [RULE15] Parallel mode: data-available flag low while a byte waits.
// [RULE16] Parallel mode: space-available flag low while a byte may be stored.
// [RULE17] Fetch strobe low drives the byte; its fall advances to the next.
// [RULE18] Each fall of the store strobe captures the bus byte; code drops it if rx buffer full or a serial write lands then.
// [RULE19] Data-available flag stays high at least 80 ns after a fetch.
// [RULE20] The parallel port uses one two-way 8-bit bus for both directions.
// [RULE21] Setup 1,0 data read; 1,1 status read; 0,0 data write; 0,1 undefined.
// [RULE22] One byte per frame, most significant bit first both ways.
// [RULE23] SDI, SDO and chip select all act on rising serial clock edges.
// [RULE24] Master drops chip select a clock between data frames.
// [RULE25] Setup 0,1 is a no-operation answered with result 1.
`ifndef SPI_FIFO_CONSTS_SVH
`define SPI_FIFO_CONSTS_SVH
`define QUEUE_DEPTH        16
`define QUEUE_PTR_W        4
`define QUEUE_PTR_ONE      5'h01
`define STATE_RX_FULL_BIT  0
`define STATE_TX_EMPTY_BIT 1
`define STATE_RX_IRQ_BIT   4
`define STATE_TX_IRQ_BIT   5
`define LAST_DATA_INDEX    3'h7
`define SNAP_POP_ECHO      19
`define SNAP_PUSH_ECHO     18
`define SNAP_HEAD_VALID    17
`define SNAP_SPACE_OK      16
`define CLK_FREQ_MHZ       20
`define CLK_PERIOD_NS      (1000 / `CLK_FREQ_MHZ)
`define AVAIL_HOLD_NS      80
`define AVAIL_HOLD_CYCLES  \
	((`AVAIL_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PIN_SYNC_RESET     11'h200
`endif

// ===== verilog/spi_fifo_pkg.sv
`default_nettype none
package spi_fifo_pkg;
	typedef enum logic [2:0] {
		LINK_IDLE   = 3'h0,
		LINK_DIR    = 3'h1,
		LINK_TARGET = 3'h2,
		LINK_DATA   = 3'h3,
		LINK_RESULT = 3'h4,
		LINK_TAIL   = 3'h5
	} link_state_type;
	typedef enum logic [1:0] {
		OP_DATA_READ   = 2'h0,
		OP_STATUS_READ = 2'h1,
		OP_DATA_WRITE  = 2'h2,
		OP_NONE        = 2'h3
	} link_op_type;
endpackage
`default_nettype wire

// ===== verilog/bit_sync.sv
`timescale 1ns/1ns
`default_nettype none
module bit_sync #(
	parameter int               WIDTH       = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input  wire logic [WIDTH-1:0] din,
	input  wire logic             clk,
	input  wire logic             resetn,
	output logic      [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] stage;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			stage <= RESET_VALUE;
			dout  <= RESET_VALUE;
		end else begin
			stage <= din;
			dout  <= stage;
		end
	end
endmodule
`default_nettype wire

// ===== verilog/byte_queue.sv
`timescale 1ns/1ns
`default_nettype none
`include "spi_fifo_consts.svh"
module byte_queue (
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       push,
	input  wire logic [7:0] pushData,
	input  wire logic       pop,
	output logic      [7:0] head,
	output logic            empty,
	output logic            full
);
	logic [7:0]              store [0:`QUEUE_DEPTH-1];
	logic [`QUEUE_PTR_W:0]   wrPtr;
	logic [`QUEUE_PTR_W:0]   rdPtr;
	wire logic               doPush = push && !full;
	wire logic               doPop  = pop && !empty;

	assign empty = wrPtr == rdPtr;
	assign full  = (wrPtr[`QUEUE_PTR_W-1:0] == rdPtr[`QUEUE_PTR_W-1:0])
		&& (wrPtr[`QUEUE_PTR_W] != rdPtr[`QUEUE_PTR_W]);
	assign head  = store[rdPtr[`QUEUE_PTR_W-1:0]];

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wrPtr <= '0;
			rdPtr <= '0;
		end else begin
			if (doPush) begin
				wrPtr <= wrPtr + `QUEUE_PTR_ONE;
			end
			if (doPop) begin
				rdPtr <= rdPtr + `QUEUE_PTR_ONE;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (doPush) begin
			store[wrPtr[`QUEUE_PTR_W-1:0]] <= pushData;
		end
	end
endmodule
`default_nettype wire

// ===== verilog/host_spi_fifo_command_port.sv
`timescale 1ns/1ns
`default_nettype none
`include "spi_fifo_consts.svh"
module host_spi_fifo_command_port
	import spi_fifo_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       spiSclk,
	input  wire logic       spiCs,
	input  wire logic       spiSdi,
	output logic            spiSdo,
	input  wire logic       fifoModeSel,
	input  wire logic       fetchStrobeN,
	input  wire logic       storeStrobe,
	input  wire logic [7:0] fifo_byte_bus_in,
	output logic      [7:0] fifo_byte_bus_out,
	output logic            fifo_byte_bus_oe,
	output logic            host_data_avail_n,
	output logic            host_space_avail_n,
	input  wire logic       rx_avail_irq_enable,
	input  wire logic       tx_space_irq_enable,
	input  wire logic       fwTxValid,
	input  wire logic [7:0] fwTxData,
	output logic            fwTxReady,
	output logic            fwRxValid,
	output logic      [7:0] fwRxData,
	input  wire logic       fwRxReady,
	output logic      [7:0] spiBufferStateByte
);
	// ------------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------------
	function automatic link_op_type decodeOp(input logic dir,
		input logic target);
		case ({dir, target})
		2'b10: decodeOp = OP_DATA_READ;
		2'b11: decodeOp = OP_STATUS_READ;
		2'b00: decodeOp = OP_DATA_WRITE;
		default: decodeOp = OP_NONE;
		endcase
	endfunction

	function automatic logic [7:0] stateByteOf(input logic rxFull,
		input logic txEmpty, input logic rxIrq, input logic txIrq);
		logic [7:0] value;
		value = 8'h00;
		value[`STATE_RX_FULL_BIT]  = rxFull;
		value[`STATE_TX_EMPTY_BIT] = txEmpty;
		value[`STATE_RX_IRQ_BIT]   = rxIrq;
		value[`STATE_TX_IRQ_BIT]   = txIrq;
		stateByteOf = value;
	endfunction

	function automatic logic holdDone(input logic [1:0] count);
		holdDone = count == 2'h0;
	endfunction

	// ------------------------------------------------------------------
	// Pin synchronisers and edge detection
	// ------------------------------------------------------------------
	logic [10:0] pinSync;
	logic        fetchLowPrev;
	logic        storeLevelPrev;

	bit_sync #(.WIDTH(11), .RESET_VALUE(`PIN_SYNC_RESET)) u_pinSync (
		.din    ({fifoModeSel, fetchStrobeN, storeStrobe,
			fifo_byte_bus_in}),
		.clk    (clk),
		.resetn (resetn),
		.dout   (pinSync)
	);

	wire logic       fifoMode   = pinSync[10];
	wire logic       fetchLow   = !pinSync[9];
	wire logic       storeLevel = pinSync[8];
	wire logic [7:0] busSample  = pinSync[7:0];
	wire logic       fetchFall  = fetchLow && !fetchLowPrev;
	wire logic       fetchRise  = !fetchLow && fetchLowPrev;
	wire logic       storeFall  = !storeLevel && storeLevelPrev;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			fetchLowPrev   <= 1'b0;
			storeLevelPrev <= 1'b0;
		end else begin
			fetchLowPrev   <= fetchLow;
			storeLevelPrev <= storeLevel;
		end
	end

	// ------------------------------------------------------------------
	// Buffers
	// ------------------------------------------------------------------
	logic [7:0] toHostHead;
	logic       toHostEmpty;
	logic       toHostFull;
	logic       fromHostEmpty;
	logic       fromHostFull;
	logic       spiPopReq;
	logic       spiPushReq;
	logic [7:0] pushByte;

	wire logic       fifoPop  = fifoMode && fetchFall && !toHostEmpty;
	wire logic       fifoPush = fifoMode && storeFall
		&& !fromHostFull; // [RULE18]
	wire logic       fromPush = spiPushReq || fifoPush;
	wire logic [7:0] fromData = spiPushReq ? pushByte : busSample;

	byte_queue u_toHost (
		.clk      (clk),
		.resetn   (resetn),
		.push     (fwTxValid),
		.pushData (fwTxData),
		.pop      (spiPopReq || fifoPop),
		.head     (toHostHead),
		.empty    (toHostEmpty),
		.full     (toHostFull)
	);

	byte_queue u_fromHost (
		.clk      (clk),
		.resetn   (resetn),
		.push     (fromPush),
		.pushData (fromData),
		.pop      (fwRxReady),
		.head     (fwRxData),
		.empty    (fromHostEmpty),
		.full     (fromHostFull)
	);

	assign fwTxReady = !toHostFull;
	assign fwRxValid = !fromHostEmpty;

	// ------------------------------------------------------------------
	// Parallel port
	// ------------------------------------------------------------------
	logic [1:0] availHold;
	logic [1:0] spaceHold;

	assign fifo_byte_bus_oe   = fifoMode && fetchLow; // [RULE17] [RULE20]
	assign host_data_avail_n  = !(fifoMode && !toHostEmpty && !fetchLow
		&& !fetchLowPrev && holdDone(availHold)); // [RULE15] [RULE19]
	assign host_space_avail_n = !(fifoMode && !fromHostFull && !storeFall
		&& holdDone(spaceHold)); // [RULE16]

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			fifo_byte_bus_out <= 8'h00;
		end else if (fifoPop) begin
			fifo_byte_bus_out <= toHostHead; // [RULE17]
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			availHold <= 2'h0;
		end else if (fetchRise) begin
			availHold <= 2'(`AVAIL_HOLD_CYCLES); // [RULE19]
		end else if (!holdDone(availHold)) begin
			availHold <= availHold - 2'h1;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			spaceHold <= 2'h0;
		end else if (storeFall) begin
			spaceHold <= 2'(`AVAIL_HOLD_CYCLES);
		end else if (!holdDone(spaceHold)) begin
			spaceHold <= spaceHold - 2'h1;
		end
	end

	// ------------------------------------------------------------------
	// Status byte and snapshot towards the serial link
	// ------------------------------------------------------------------
	logic [19:0] snapWord;
	logic        offerTog;
	logic        popSeen;
	logic        pushSeen;
	logic [2:0]  linkTogSync;
	logic        ackTog;
	logic        popTog;
	logic        pushTog;

	wire logic [7:0] stateNow = stateByteOf(fromHostFull, toHostEmpty,
		rx_avail_irq_enable, tx_space_irq_enable); // [RULE13]
	wire logic       ackSeen  = linkTogSync[2];
	wire logic       offerIdle = offerTog == ackSeen;

	bit_sync #(.WIDTH(3), .RESET_VALUE(3'h0)) u_linkTogSync (
		.din    ({ackTog, popTog, pushTog}),
		.clk    (clk),
		.resetn (resetn),
		.dout   (linkTogSync)
	);

	assign spiPopReq  = linkTogSync[1] != popSeen;
	assign spiPushReq = linkTogSync[0] != pushSeen;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			spiBufferStateByte <= 8'h00;
			popSeen            <= 1'b0;
			pushSeen           <= 1'b0;
		end else begin
			spiBufferStateByte <= stateNow;
			popSeen            <= linkTogSync[1]; // [RULE3]
			pushSeen           <= linkTogSync[0]; // [RULE9]
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			snapWord <= 20'h00000;
			offerTog <= 1'b0;
		end else if (offerIdle) begin
			snapWord <= {popSeen, pushSeen, !fifoMode && !toHostEmpty,
				!fifoMode && !fromHostFull, stateNow, toHostHead};
			offerTog <= !offerTog;
		end
	end

	// ------------------------------------------------------------------
	// Serial link on the master clock
	// ------------------------------------------------------------------
	link_state_type linkState;
	link_state_type next_linkState;
	link_op_type    linkOp;
	link_op_type    next_linkOp;
	logic [2:0]     linkCount;
	logic [2:0]     next_linkCount;
	logic [7:0]     shiftReg;
	logic [7:0]     next_shiftReg;
	logic [7:0]     lastByte;
	logic [7:0]     next_lastByte;
	logic [7:0]     next_pushByte;
	logic [19:0]    linkSnap;
	logic           dirBit;
	logic           next_dirBit;
	logic           readFresh;
	logic           next_readFresh;
	logic           next_spiSdo;
	logic           next_popTog;
	logic           next_pushTog;
	logic           offerSeen;

	bit_sync #(.WIDTH(1), .RESET_VALUE(1'b0)) u_offerSync (
		.din    (offerTog),
		.clk    (spiSclk),
		.resetn (resetn),
		.dout   (offerSeen)
	);

	wire logic [7:0]  snapHead   = linkSnap[7:0];
	wire logic [7:0]  snapState  = linkSnap[15:8];
	wire logic        freshAvail = linkSnap[`SNAP_HEAD_VALID]
		&& (linkSnap[`SNAP_POP_ECHO] == popTog);
	wire logic        spaceAvail = linkSnap[`SNAP_SPACE_OK]
		&& (linkSnap[`SNAP_PUSH_ECHO] == pushTog);
	wire link_op_type setupOp    = decodeOp(dirBit, spiSdi); // [RULE21]
	wire logic [7:0]  loadByte   = (setupOp == OP_DATA_READ)
		? (freshAvail ? snapHead : lastByte)
		: (setupOp == OP_STATUS_READ) ? snapState : 8'h00; // [RULE12]
	wire logic [7:0]  shiftedByte = {shiftReg[6:0], spiSdi}; // [RULE22]
	wire logic        resultBit  = (linkOp == OP_DATA_READ) ? !readFresh
		: (linkOp == OP_DATA_WRITE) ? !spaceAvail
		: (linkOp == OP_NONE); // [RULE3] [RULE9] [RULE12] [RULE25]

	always_ff @(posedge spiSclk or negedge resetn) begin
		if (!resetn) begin
			linkSnap <= 20'h00000;
			ackTog   <= 1'b0;
		end else if (offerSeen != ackTog) begin
			linkSnap <= snapWord;
			ackTog   <= offerSeen;
		end
	end

	always_comb begin
		next_linkState = linkState;
		next_linkOp    = linkOp;
		next_linkCount = linkCount;
		next_shiftReg  = shiftReg;
		next_lastByte  = lastByte;
		next_pushByte  = pushByte;
		next_dirBit    = dirBit;
		next_readFresh = readFresh;
		next_spiSdo    = spiSdo;
		next_popTog    = popTog;
		next_pushTog   = pushTog;
		case (linkState)
		LINK_IDLE: begin
			next_spiSdo = 1'b0;
			if (spiCs && spiSdi) begin
				next_linkState = LINK_DIR; // [RULE7]
			end
		end
		LINK_DIR: begin
			next_dirBit    = spiSdi;
			next_linkState = LINK_TARGET;
		end
		LINK_TARGET: begin
			next_linkOp    = setupOp;
			next_readFresh = freshAvail && (setupOp == OP_DATA_READ);
			next_shiftReg  = loadByte;
			next_spiSdo    = loadByte[7]; // [RULE2] [RULE22]
			next_linkCount = 3'h0;
			next_linkState = LINK_DATA;
			if (setupOp == OP_DATA_READ && freshAvail) begin
				next_lastByte = snapHead;
			end
		end
		LINK_DATA: begin
			next_shiftReg  = shiftedByte;
			next_spiSdo    = shiftedByte[7];
			next_linkCount = linkCount + 3'h1;
			if (linkCount == `LAST_DATA_INDEX) begin
				next_spiSdo    = resultBit; // [RULE8]
				next_linkState = LINK_RESULT;
				if (linkOp == OP_DATA_READ && readFresh) begin
					next_popTog = !popTog; // [RULE3]
				end
				if (linkOp == OP_DATA_WRITE && spaceAvail) begin
					next_pushTog  = !pushTog; // [RULE9]
					next_pushByte = shiftedByte;
				end
			end
		end
		LINK_RESULT: begin
			next_spiSdo    = 1'b0; // [RULE5]
			next_linkState = LINK_TAIL;
		end
		default: begin
			next_spiSdo    = 1'b0;
			next_linkState = LINK_IDLE; // [RULE7]
		end
		endcase
		if (!spiCs && linkState != LINK_IDLE) begin
			next_linkState = LINK_IDLE;
			next_spiSdo    = 1'b0;
			next_popTog    = popTog;
			next_pushTog   = pushTog;
		end
	end

	always_ff @(posedge spiSclk or negedge resetn) begin // [RULE23]
		if (!resetn) begin
			linkState <= LINK_IDLE;
			linkOp    <= OP_NONE;
			linkCount <= 3'h0;
			shiftReg  <= 8'h00;
			lastByte  <= 8'h00;
			pushByte  <= 8'h00;
			dirBit    <= 1'b0;
			readFresh <= 1'b0;
			spiSdo    <= 1'b0;
			popTog    <= 1'b0;
			pushTog   <= 1'b0;
		end else begin
			linkState <= next_linkState;
			linkOp    <= next_linkOp;
			linkCount <= next_linkCount;
			shiftReg  <= next_shiftReg;
			lastByte  <= next_lastByte;
			pushByte  <= next_pushByte;
			dirBit    <= next_dirBit;
			readFresh <= next_readFresh;
			spiSdo    <= next_spiSdo;
			popTog    <= next_popTog;
			pushTog   <= next_pushTog;
		end
	end

	// ------------------------------------------------------------------
	// Checks on the serial link
	// ------------------------------------------------------------------
	chk_frame_length: assert property ( // [RULE7]
		@(posedge spiSclk) disable iff (!resetn)
		(linkState == LINK_IDLE && spiCs && spiSdi)
		##1 spiCs [*8] ##1 spiCs [*3]
		|=> linkState == LINK_TAIL ##1 linkState == LINK_IDLE)
		else $error("Frame did not last thirteen clocks.");

	chk_read_pop: assert property ( // [RULE3]
		@(posedge spiSclk) disable iff (!resetn)
		(linkState == LINK_DATA && linkCount == 3'h7 && spiCs
		&& linkOp == OP_DATA_READ)
		|=> (spiSdo == (popTog == $past(popTog))))
		else $error("Read result does not match buffer removal.");

	chk_write_push: assert property ( // [RULE9]
		@(posedge spiSclk) disable iff (!resetn)
		(linkState == LINK_DATA && linkCount == 3'h7 && spiCs
		&& linkOp == OP_DATA_WRITE)
		|=> (spiSdo == (pushTog == $past(pushTog)))
		&& (pushTog == $past(pushTog) || pushByte == $past(shiftedByte)))
		else $error("Write result does not match byte storage.");

	chk_status_zero: assert property ( // [RULE12]
		@(posedge spiSclk) disable iff (!resetn)
		(linkState == LINK_RESULT && linkOp == OP_STATUS_READ)
		|-> !spiSdo)
		else $error("Status read result is not zero.");

	chk_noop_result: assert property ( // [RULE25]
		@(posedge spiSclk) disable iff (!resetn)
		(linkState == LINK_RESULT && linkOp == OP_NONE)
		|-> spiSdo && $stable(popTog) && $stable(pushTog))
		else $error("Undefined setup touched a buffer or answered 0.");

	chk_result_drop: assert property ( // [RULE5]
		@(posedge spiSclk) disable iff (!resetn)
		(linkState == LINK_RESULT) |=> !spiSdo)
		else $error("Result bit held past its edge.");

	// ------------------------------------------------------------------
	// Checks on the parallel port
	// ------------------------------------------------------------------
	chk_avail_hold: assert property ( // [RULE19]
		@(posedge clk) disable iff (!resetn)
		fetchRise |-> host_data_avail_n [*3])
		else $error("Data flag returned too soon after a fetch.");

	chk_avail_flag: assert property ( // [RULE15]
		@(posedge clk) disable iff (!resetn)
		!host_data_avail_n |-> fifoMode && !toHostEmpty)
		else $error("Data flag low with nothing to fetch.");

	chk_space_flag: assert property ( // [RULE16]
		@(posedge clk) disable iff (!resetn)
		!host_space_avail_n |-> fifoMode && !fromHostFull)
		else $error("Space flag low with no room.");

	chk_fetch_byte: assert property ( // [RULE17]
		@(posedge clk) disable iff (!resetn)
		(fetchFall && fifoMode && !toHostEmpty)
		|=> fifo_byte_bus_out == $past(toHostHead) && fifo_byte_bus_oe)
		else $error("Fetched byte not presented on the bus.");

	chk_store_push: assert property ( // [RULE18]
		@(posedge clk) disable iff (!resetn)
		(storeFall && fifoMode && !fromHostFull && !spiPushReq)
		|-> fromPush && fromData == busSample)
		else $error("Store strobe did not capture the bus byte.");
endmodule
`default_nettype wire

// ===== dv/spi_master_model.sv
`timescale 1ns/1ns
`default_nettype none
module spi_master_model (
	output logic      spiSclk,
	output logic      spiCs,
	output logic      spiSdi,
	input  wire logic spiSdo
);
	// --------------------------------------------------------------
	// Serial master that clocks only inside frames and idle gaps.
	// --------------------------------------------------------------
	initial begin
		spiSclk = 1'b0;
		spiCs = 1'b0;
		spiSdi = 1'b0;
	end

	task automatic idle(input int n);
		repeat (n) begin
			spiCs = 1'b0;
			spiSdi = ~spiSdi;
			#32 spiSclk = 1'b1;
			#32 spiSclk = 1'b0;
		end
	endtask

	task automatic frame(input logic dir, input logic tgt,
		input logic [7:0] tx, output logic [7:0] rx,
		output logic [1:0] res);
		logic [12:0] seq;
		seq = {1'b1, dir, tgt, tx, 2'b00};
		rx = 8'h00;
		res = 2'h3;
		// Idle clocks first let the buffer snapshot reach the serial side.
		idle(10);
		for (int k = 0; k < 13; k++) begin
			spiCs = 1'b1;
			spiSdi = seq[12-k];
			#32 spiSclk = 1'b1;
			#32 spiSclk = 1'b0;
			if (k >= 2 && k <= 9) rx = {rx[6:0], spiSdo};
			if (k == 10) res[1] = spiSdo;
			if (k == 11) res[0] = spiSdo;
		end
		idle(6);
	endtask
endmodule
`default_nettype wire

// ===== dv/host_spi_fifo_command_port_bench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHECK(n, e, g) check(n, 8'(e), 8'(g))
module host_spi_fifo_command_port_bench;
	logic       clk, resetn, spiSclk, spiCs, spiSdi, spiSdo;
	logic       fifoModeSel, fetchStrobeN, storeStrobe, busOe;
	logic       dataAvailN, spaceAvailN, rxIrqEn, txIrqEn, hostOe;
	logic       fwTxValid, fwTxReady, fwRxValid, fwRxReady;
	logic [7:0] fwTxData, fwRxData, busOut, stateByte, hostByte;
	wire  [7:0] busWire;
	int         failures, compares, cycles;

	assign busWire = busOe ? busOut : (hostOe ? hostByte : ~hostByte);

	host_spi_fifo_command_port u_dut (
		.clk(clk), .resetn(resetn), .spiSclk(spiSclk), .spiCs(spiCs),
		.spiSdi(spiSdi), .spiSdo(spiSdo), .fifoModeSel(fifoModeSel),
		.fetchStrobeN(fetchStrobeN), .storeStrobe(storeStrobe),
		.fifo_byte_bus_in(busWire), .fifo_byte_bus_out(busOut),
		.fifo_byte_bus_oe(busOe), .host_data_avail_n(dataAvailN),
		.host_space_avail_n(spaceAvailN),
		.rx_avail_irq_enable(rxIrqEn), .tx_space_irq_enable(txIrqEn),
		.fwTxValid(fwTxValid), .fwTxData(fwTxData),
		.fwTxReady(fwTxReady), .fwRxValid(fwRxValid),
		.fwRxData(fwRxData), .fwRxReady(fwRxReady),
		.spiBufferStateByte(stateByte)
	);

	spi_master_model u_master (
		.spiSclk(spiSclk), .spiCs(spiCs), .spiSdi(spiSdi), .spiSdo(spiSdo)
	);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			wrap_up;
		end
	end

	// --------------------------------------------------------------
	// Shared tasks.
	// --------------------------------------------------------------
	task automatic wrap_up;
		if (failures == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic check(input string n, input logic [7:0] e,
		input logic [7:0] g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic spiOp(input string n, input logic dir, input logic tgt,
		input logic [7:0] tx, input logic [7:0] expRx,
		input logic expRes, input bit chkRx);
		logic [7:0] rx;
		logic [1:0] res;
		u_master.frame(dir, tgt, tx, rx, res);
		if (chkRx) `CHECK(n, expRx, rx);
		`CHECK("spi result", {expRes, 1'b0}, res);
	endtask

	task automatic fwPush(input logic [7:0] b);
		@(negedge clk);
		fwTxValid = 1'b1;
		fwTxData = b;
		`CHECK("tx ready", 1'b1, fwTxReady);
		@(negedge clk);
		fwTxValid = 1'b0;
	endtask

	task automatic fwPop(input logic [7:0] e);
		int i;
		@(negedge clk);
		for (i = 0; i < 40 && fwRxValid !== 1'b1; i++) @(negedge clk);
		`CHECK("rx valid", 1'b1, fwRxValid);
		`CHECK("rx byte", e, fwRxData);
		fwRxReady = 1'b1;
		@(negedge clk);
		fwRxReady = 1'b0;
	endtask

	task automatic fetch(input logic [7:0] e);
		int i;
		fetchStrobeN = 1'b0;
		repeat (4) @(negedge clk);
		`CHECK("bus oe", 1'b1, busOe);
		`CHECK("fetch byte", e, busWire);
		fetchStrobeN = 1'b1;
		for (i = 0; i < 10 && busOe !== 1'b0; i++) @(negedge clk);
		`CHECK("avail hold", 1'b1, dataAvailN);
		@(negedge clk);
		`CHECK("avail hold", 1'b1, dataAvailN);
	endtask

	// --------------------------------------------------------------
	// Test sequence.
	// --------------------------------------------------------------
	initial begin
		failures = 0;
		compares = 0;
		cycles = 0;
		resetn = 1'b0;
		fifoModeSel = 1'b0;
		fetchStrobeN = 1'b1;
		storeStrobe = 1'b0;
		rxIrqEn = 1'b0;
		txIrqEn = 1'b0;
		hostOe = 1'b0;
		hostByte = 8'h00;
		fwTxValid = 1'b0;
		fwTxData = 8'h00;
		fwRxReady = 1'b0;
		fork
			u_master.idle(4);
			repeat (10) @(posedge clk);
		join
		`CHECK("reset sdo", 1'b0, spiSdo);
		`CHECK("reset state", 8'h00, stateByte);
		`CHECK("reset avail", 1'b1, dataAvailN);
		`CHECK("reset space", 1'b1, spaceAvailN);
		@(negedge clk) resetn = 1'b1;
		u_master.idle(10);
		spiOp("poll", 1, 0, 8'h00, 8'h00, 1, 1);
		rxIrqEn = 1'b1;
		spiOp("status", 1, 1, 8'h00, 8'h12, 0, 1);
		rxIrqEn = 1'b0;
		txIrqEn = 1'b1;
		spiOp("status", 1, 1, 8'h00, 8'h22, 0, 1);
		txIrqEn = 1'b0;
		fwPush(8'hA5);
		fwPush(8'h3C);
		spiOp("status", 1, 1, 8'h00, 8'h00, 0, 1);
		spiOp("read", 1, 0, 8'h00, 8'hA5, 0, 1);
		spiOp("read", 1, 0, 8'h00, 8'h3C, 0, 1);
		spiOp("read", 1, 0, 8'h00, 8'h3C, 1, 1);
		spiOp("read", 1, 0, 8'h00, 8'h3C, 1, 1);
		for (int i = 0; i < 16; i++)
			spiOp("write", 0, 0, 8'(8'h10 + i), 8'h00, 0, 0);
		spiOp("write", 0, 0, 8'hEE, 8'h00, 1, 0);
		`CHECK("state byte", 8'h03, stateByte);
		spiOp("status", 1, 1, 8'h00, 8'h03, 0, 1);
		fwPop(8'h10);
		spiOp("write", 0, 0, 8'hEE, 8'h00, 0, 0);
		for (int i = 1; i < 16; i++)
			fwPop(8'(8'h10 + i));
		fwPop(8'hEE);
		spiOp("noop", 0, 1, 8'h77, 8'h00, 1, 0);
		`CHECK("noop rx", 1'b0, fwRxValid);
		spiOp("status", 1, 1, 8'h00, 8'h02, 0, 1);
		@(negedge clk) fifoModeSel = 1'b1;
		repeat (4) @(negedge clk);
		`CHECK("space", 1'b0, spaceAvailN);
		`CHECK("avail", 1'b1, dataAvailN);
		fwPush(8'hC3);
		fwPush(8'h96);
		repeat (4) @(negedge clk);
		`CHECK("avail", 1'b0, dataAvailN);
		fetch(8'hC3);
		repeat (4) @(negedge clk);
		fetch(8'h96);
		repeat (6) @(negedge clk);
		`CHECK("avail empty", 1'b1, dataAvailN);
		hostOe = 1'b1;
		hostByte = 8'h5A;
		storeStrobe = 1'b1;
		repeat (4) @(negedge clk);
		storeStrobe = 1'b0;
		repeat (4) @(negedge clk);
		hostOe = 1'b0;
		fwPop(8'h5A);
		wrap_up;
	end
endmodule
`default_nettype wire
